/* inc/aops_consts.vh */
// constants of the angle output and programming stage
// ----------------------------------------------------------------
// ----------------------------------------------------------------
`ifndef AOPS_CONSTS_VH
`define AOPS_CONSTS_VH

`define AOPS_CLK_MHZ       20
`define AOPS_APPLY_US      1000
`define AOPS_APPLY_CYC     (`AOPS_APPLY_US * `AOPS_CLK_MHZ)
`define AOPS_PULSE_MS      100
`define AOPS_PULSE_CYC     (`AOPS_PULSE_MS * 1000 * `AOPS_CLK_MHZ)

`define AOPS_CMD_BURN_SET  8'h40
`define AOPS_CMD_LOAD_A    8'h01
`define AOPS_CMD_LOAD_B    8'h11
`define AOPS_CMD_LOAD_C    8'h10

`define AOPS_OUTPUT_FORM_SELECT_LSB      4
`define AOPS_OUTPUT_FORM_SELECT_MSB      5
`define AOPS_PWM_RATE_SELECT_LSB      6
`define AOPS_PWM_RATE_SELECT_MSB      7
`define AOPS_OUTPUT_FORM_SELECT_FULL     2'h0
`define AOPS_OUTPUT_FORM_SELECT_REDUCED  2'h1
`define AOPS_OUTPUT_FORM_SELECT_PWM      2'h2

`define AOPS_CONFIG_WORD_RST      14'h0000
`define AOPS_ZERO_POSITION_VALUE_RST      12'h000
`define AOPS_MAX_RANGE_VALUE_RST      12'h000
`define AOPS_MAX_RANGE_VALUE_MIN      12'h0CD
`define AOPS_HYST          12'h00A
`define AOPS_CODE_MAX      12'hFFF
`define AOPS_LOW_OFS       12'h19A
`define AOPS_SWING         12'hCCD

`define AOPS_PWM_EDGE      13'h0080
`define AOPS_PWM_FRAME     13'h10FF
`define AOPS_PWM_BASE_DIV  8'h04

`endif

/* logic/aops_div.v */
// sequential restoring divider for range scaling
`timescale 1ns/1ps
module aops_div (
   // clock and reset
   input  wire        clk,
   input  wire        rst_n,
   // request
   input  wire        start,
   input  wire [23:0] num,
   input  wire [12:0] den,
   // answer
   output reg         done,
   output wire [12:0] quo
);
   reg  [23:0] q;
   reg  [12:0] r;
   reg  [4:0]  n;
   wire [13:0] sh   = {r, q[23]};
   wire [13:0] diff = sh - {1'b0, den};

   assign quo = q[12:0];

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q    <= 24'h000000;
         r    <= 13'h0000;
         n    <= 5'h00;
         done <= 1'b0;
      end else begin
         done <= 1'b0;
         if (n != 5'h00) begin
            if (!diff[13]) begin
               r <= diff[12:0];
               q <= {q[22:0], 1'b1};
            end else begin
               r <= sh[12:0];
               q <= {q[22:0], 1'b0};
            end
            n <= n - 5'h01;
            if (n == 5'h01)
               done <= 1'b1;
         end else if (start) begin
            q <= num;
            r <= 13'h0000;
            n <= 5'h18;
         end
      end
   end
endmodule // aops_div

/* logic/aops_pwm.v */
// pwm frame generator for the output pin
`timescale 1ns/1ps
`include "aops_consts.vh"
module aops_pwm (
   // clock and reset
   input  wire        clk,
   input  wire        rst_n,
   // control
   input  wire [1:0]  rate,
   input  wire [11:0] value,
   // output
   output reg         pwm
);
   reg  [7:0]  pre;
   reg  [12:0] cnt;
   reg  [12:0] hi_len;
   wire [7:0]  pre_top = (`AOPS_PWM_BASE_DIV << rate) - 8'h01;

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pre    <= 8'h00;
         cnt    <= 13'h0000;
         hi_len <= `AOPS_PWM_EDGE;
         pwm    <= 1'b0;
      end else begin
         if (pre >= pre_top) begin
            pre <= 8'h00;
            if (cnt == `AOPS_PWM_FRAME - 13'h0001) begin
               cnt    <= 13'h0000;
               hi_len <= `AOPS_PWM_EDGE + {1'b0, value};
            end else begin
               cnt <= cnt + 13'h0001;
            end
         end else begin
            pre <= pre + 8'h01;
         end
         pwm <= (cnt < hi_len);
      end
   end
endmodule // aops_pwm

/* logic/aops_top.v */
// angle output stage with register and pin programming
`timescale 1ns/1ps
`include "aops_consts.vh"
module aops_top #(
   parameter integer APPLY_CYC = `AOPS_APPLY_CYC,
   parameter integer PULSE_CYC = `AOPS_PULSE_CYC
) (
   // clock and reset
   input  wire        CORE_CLK,
   input  wire        RST_N,
   // angle source
   input  wire [11:0] RAW_ANGLE,
   input  wire        MAGNET_PRESENT_FLAG,
   // register writes from the serial slave
   input  wire        ZERO_POSITION_WR,
   input  wire [11:0] ZERO_POSITION_DATA,
   input  wire        MAX_RANGE_WR,
   input  wire [11:0] MAX_RANGE_DATA,
   input  wire        CONFIG_WR,
   input  wire [13:0] CONFIG_DATA,
   input  wire        COMMAND_WR,
   input  wire [7:0]  COMMAND_DATA,
   // register readback
   output reg  [11:0] ANGLE_VALUE,
   output reg  [11:0] ZERO_POSITION_VALUE,
   output reg  [11:0] MAX_RANGE_VALUE,
   output reg  [13:0] CONFIG_WORD,
   output reg         SETTINGS_BURNED,
   output reg         PIN_PROG_DONE,
   output reg         PIN_PROG_FAIL,
   // pins
   input  wire        PROGRAM_OPTION_PIN,
   input  wire        OUT_IN,
   output reg         OUT_O,
   output reg         OUT_OE_N,
   // converter
   output reg  [11:0] DAC_CODE,
   output reg         DAC_POWER_DOWN
);
   // ---------------------------------------------------------------
   // reset release and pin synchronisers
   // ---------------------------------------------------------------
   reg [1:0] rst_sync;
   wire      rst_n = rst_sync[1];
   reg [2:0] out_s;
   reg [2:0] pgo_s;
   reg       out_lvl;
   reg       pgo_lvl;

   always @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N)
         rst_sync <= 2'b00;
      else
         rst_sync <= {rst_sync[0], 1'b1};
   end

   always @(posedge CORE_CLK or negedge rst_n) begin
      if (!rst_n) begin
         out_s   <= 3'b111;
         pgo_s   <= 3'b111;
         out_lvl <= 1'b1;
         pgo_lvl <= 1'b1;
      end else begin
         out_s <= {out_s[1:0], OUT_IN};
         pgo_s <= {pgo_s[1:0], PROGRAM_OPTION_PIN};
         if (out_s[2] == out_s[1])
            out_lvl <= out_s[1];
         if (pgo_s[2] == pgo_s[1])
            pgo_lvl <= pgo_s[1];
      end
   end

   // ---------------------------------------------------------------
   // programming state machine on the output pin
   // ---------------------------------------------------------------
   localparam [5:0] S_IDLE = 6'h01;
   localparam [5:0] S_LOW1 = 6'h02;
   localparam [5:0] S_GAP  = 6'h04;
   localparam [5:0] S_LOW2 = 6'h08;
   localparam [5:0] S_DONE = 6'h10;
   localparam [5:0] S_FAIL = 6'h20;
   localparam [21:0] PULSE_LEN = PULSE_CYC[21:0];

   reg  [5:0]  state;
   reg  [21:0] pcnt;
   reg  [11:0] start_pos;
   reg         pin_wr;
   reg  [11:0] pin_span;
   wire        pin_open  = !pgo_lvl && state != S_DONE && state != S_FAIL;
   wire        long_low  = (pcnt >= PULSE_LEN);
   wire [11:0] span      = RAW_ANGLE - start_pos;

   always @(posedge CORE_CLK or negedge rst_n) begin
      if (!rst_n) begin
         state     <= S_IDLE;
         pcnt      <= 22'h000000;
         start_pos <= 12'h000;
         pin_wr    <= 1'b0;
         pin_span  <= 12'h000;
      end else begin
         pin_wr <= 1'b0;
         if (state == S_LOW1 || state == S_LOW2)
            pcnt <= long_low ? pcnt : pcnt + 22'h000001;
         else
            pcnt <= 22'h000000;
         if (!MAGNET_PRESENT_FLAG && state != S_DONE && state != S_FAIL) begin
            state <= S_IDLE;
         end else begin
            case (state)
               S_IDLE: begin
                  if (pin_open && !out_lvl)
                     state <= S_LOW1;
               end
               S_LOW1: begin
                  if (out_lvl) begin
                     if (long_low) begin
                        start_pos <= RAW_ANGLE;
                        state     <= S_GAP;
                     end else begin
                        state <= S_IDLE;
                     end
                  end
               end
               S_GAP: begin
                  if (pgo_lvl)
                     state <= S_IDLE;
                  else if (!out_lvl)
                     state <= S_LOW2;
               end
               S_LOW2: begin
                  if (out_lvl) begin
                     if (!long_low) begin
                        state <= S_GAP;
                     end else if (span != 12'h000 && span < `AOPS_MAX_RANGE_VALUE_MIN) begin
                        state <= S_FAIL;
                     end else begin
                        pin_span <= span;
                        pin_wr   <= 1'b1;
                        state    <= S_DONE;
                     end
                  end
               end
               S_DONE: state <= S_DONE;
               S_FAIL: state <= S_FAIL;
               default: state <= S_IDLE;
            endcase
         end
      end
   end

   // ---------------------------------------------------------------
   // shadow, stored and active settings
   // ---------------------------------------------------------------
   reg  [11:0] otp_zero_position_value;
   reg  [11:0] otp_max_range_value;
   reg  [13:0] otp_config_word;
   reg  [11:0] act_zero_position_value;
   reg  [11:0] act_max_range_value;
   reg  [13:0] act_config_word;
   reg  [1:0]  load_seq;
   reg  [21:0] apply_cnt;
   localparam [21:0] APPLY_LEN = APPLY_CYC[21:0];
   wire        cmd_burn = COMMAND_WR && COMMAND_DATA == `AOPS_CMD_BURN_SET;
   wire        cmd_load = COMMAND_WR && COMMAND_DATA == `AOPS_CMD_LOAD_C
                          && load_seq == 2'h2;
   wire        any_cmd  = ZERO_POSITION_WR || MAX_RANGE_WR || CONFIG_WR || COMMAND_WR;
   wire        max_range_value_ok  = MAX_RANGE_DATA == 12'h000 || MAX_RANGE_DATA >= `AOPS_MAX_RANGE_VALUE_MIN;

   always @(posedge CORE_CLK or negedge rst_n) begin
      if (!rst_n) begin
         ZERO_POSITION_VALUE <= `AOPS_ZERO_POSITION_VALUE_RST;
         MAX_RANGE_VALUE     <= `AOPS_MAX_RANGE_VALUE_RST;
         CONFIG_WORD         <= `AOPS_CONFIG_WORD_RST;
         otp_zero_position_value            <= `AOPS_ZERO_POSITION_VALUE_RST;
         otp_max_range_value            <= `AOPS_MAX_RANGE_VALUE_RST;
         otp_config_word            <= `AOPS_CONFIG_WORD_RST;
         act_zero_position_value            <= `AOPS_ZERO_POSITION_VALUE_RST;
         act_max_range_value            <= `AOPS_MAX_RANGE_VALUE_RST;
         act_config_word            <= `AOPS_CONFIG_WORD_RST;
         SETTINGS_BURNED     <= 1'b0;
         load_seq            <= 2'h0;
         apply_cnt           <= 22'h000000;
      end else begin
         if (ZERO_POSITION_WR)
            ZERO_POSITION_VALUE <= ZERO_POSITION_DATA;
         if (MAX_RANGE_WR && max_range_value_ok)
            MAX_RANGE_VALUE <= MAX_RANGE_DATA;
         if (CONFIG_WR)
            CONFIG_WORD <= CONFIG_DATA;
         if (COMMAND_WR) begin
            if (COMMAND_DATA == `AOPS_CMD_LOAD_A)
               load_seq <= 2'h1;
            else if (COMMAND_DATA == `AOPS_CMD_LOAD_B && load_seq == 2'h1)
               load_seq <= 2'h2;
            else
               load_seq <= 2'h0;
         end
         if (cmd_burn && !SETTINGS_BURNED) begin
            otp_max_range_value        <= MAX_RANGE_VALUE;
            otp_config_word        <= CONFIG_WORD;
            SETTINGS_BURNED <= 1'b1;
         end
         if (cmd_load) begin
            ZERO_POSITION_VALUE <= otp_zero_position_value;
            MAX_RANGE_VALUE     <= otp_max_range_value;
            CONFIG_WORD         <= otp_config_word;
         end
         if (pin_wr) begin
            otp_zero_position_value            <= start_pos;
            otp_max_range_value            <= pin_span;
            ZERO_POSITION_VALUE <= start_pos;
            MAX_RANGE_VALUE     <= pin_span;
            act_zero_position_value            <= start_pos;
            act_max_range_value            <= pin_span;
         end else if (apply_cnt == 22'h000001) begin
            act_zero_position_value <= ZERO_POSITION_VALUE;
            act_max_range_value <= MAX_RANGE_VALUE;
            act_config_word <= CONFIG_WORD;
         end
         if (any_cmd)
            apply_cnt <= APPLY_LEN;
         else if (apply_cnt != 22'h000000)
            apply_cnt <= apply_cnt - 22'h000001;
      end
   end

   // ---------------------------------------------------------------
   // angle scaling to the programmed range
   // ---------------------------------------------------------------
   wire [11:0] rel    = RAW_ANGLE - act_zero_position_value;
   wire        full   = (act_max_range_value == 12'h000);
   wire [11:0] lam    = (12'h000 - act_max_range_value) >> 1;
   wire [11:0] beyond = rel - act_max_range_value;
   wire [11:0] rel_c  = full ? rel :
                        (rel < act_max_range_value) ? rel :
                        (beyond < lam) ? act_max_range_value : 12'h000;
   wire [12:0] den    = full ? 13'h1000 : {1'b0, act_max_range_value};
   wire [12:0] quo;
   wire        div_done;
   reg         div_go;
   reg  [11:0] code;
   wire [11:0] q_c    = quo[12] ? `AOPS_CODE_MAX : quo[11:0];

   aops_div u_div (
      .clk   (CORE_CLK),
      .rst_n (rst_n),
      .start (div_go),
      .num   ({rel_c, 12'h000}),
      .den   (den),
      .done  (div_done),
      .quo   (quo)
   );

   always @(posedge CORE_CLK or negedge rst_n) begin
      if (!rst_n) begin
         div_go      <= 1'b0;
         code        <= 12'h000;
         ANGLE_VALUE <= 12'h000;
      end else begin
         div_go <= !div_go && !div_done;
         if (div_done) begin
            if (full && code > `AOPS_CODE_MAX - `AOPS_HYST && q_c < `AOPS_HYST)
               code <= code;
            else if (full && code < `AOPS_HYST && q_c > `AOPS_CODE_MAX - `AOPS_HYST)
               code <= code;
            else
               code <= q_c;
         end
         ANGLE_VALUE <= code;
      end
   end

   // ---------------------------------------------------------------
   // output stage
   // ---------------------------------------------------------------
   wire [1:0]  output_form_select      = act_config_word[`AOPS_OUTPUT_FORM_SELECT_MSB:`AOPS_OUTPUT_FORM_SELECT_LSB];
   wire [1:0]  pwm_rate_select      = act_config_word[`AOPS_PWM_RATE_SELECT_MSB:`AOPS_PWM_RATE_SELECT_LSB];
   wire        pwm_mode  = (output_form_select == `AOPS_OUTPUT_FORM_SELECT_PWM);
   wire        force_low = (state == S_FAIL) || !MAGNET_PRESENT_FLAG;
   wire [23:0] scaled    = code * `AOPS_SWING;
   wire        pwm_bit;

   aops_pwm u_pwm (
      .clk   (CORE_CLK),
      .rst_n (rst_n),
      .rate  (pwm_rate_select),
      .value (code),
      .pwm   (pwm_bit)
   );

   always @(posedge CORE_CLK or negedge rst_n) begin
      if (!rst_n) begin
         OUT_O          <= 1'b0;
         OUT_OE_N       <= 1'b1;
         DAC_CODE       <= 12'h000;
         DAC_POWER_DOWN <= 1'b0;
         PIN_PROG_DONE  <= 1'b0;
         PIN_PROG_FAIL  <= 1'b0;
      end else begin
         PIN_PROG_DONE  <= (state == S_DONE);
         PIN_PROG_FAIL  <= (state == S_FAIL);
         DAC_POWER_DOWN <= pwm_mode;
         if (force_low) begin
            OUT_O    <= 1'b0;
            OUT_OE_N <= 1'b0;
            DAC_CODE <= 12'h000;
         end else if (pin_open) begin
            OUT_O    <= 1'b0;
            OUT_OE_N <= 1'b1;
            DAC_CODE <= code;
         end else if (pwm_mode) begin
            OUT_O    <= pwm_bit;
            OUT_OE_N <= 1'b0;
            DAC_CODE <= 12'h000;
         end else if (output_form_select == `AOPS_OUTPUT_FORM_SELECT_REDUCED) begin
            OUT_O    <= 1'b0;
            OUT_OE_N <= 1'b1;
            DAC_CODE <= `AOPS_LOW_OFS + scaled[23:12];
         end else begin
            OUT_O    <= 1'b0;
            OUT_OE_N <= 1'b1;
            DAC_CODE <= code;
         end
      end
   end
endmodule // aops_top

/* testbench/aops_top_chk.sv */
// assertion checker for the angle output stage
`timescale 1ns/1ps
`include "aops_consts.vh"
module aops_top_chk #(
   parameter integer APPLY_CYC = 20,
   parameter integer PULSE_CYC = 50
) (
   // clock and reset
   input wire        CORE_CLK,
   input wire        RST_N,
   // inputs
   input wire        MAGNET_PRESENT_FLAG,
   input wire        ZERO_POSITION_WR,
   input wire        MAX_RANGE_WR,
   input wire [11:0] MAX_RANGE_DATA,
   input wire        CONFIG_WR,
   input wire        COMMAND_WR,
   input wire [7:0]  COMMAND_DATA,
   input wire        PROGRAM_OPTION_PIN,
   // outputs
   input wire [11:0] MAX_RANGE_VALUE,
   input wire [13:0] CONFIG_WORD,
   input wire        SETTINGS_BURNED,
   input wire        PIN_PROG_DONE,
   input wire        PIN_PROG_FAIL,
   input wire        OUT_O,
   input wire        OUT_OE_N,
   input wire        DAC_POWER_DOWN
);
   default clocking cb @(posedge CORE_CLK);
   endclocking
   default disable iff (!RST_N);
   reg  [31:0] since_cmd;
   wire        any_wr = ZERO_POSITION_WR | MAX_RANGE_WR | CONFIG_WR | COMMAND_WR;
   // cycles since the last write, saturating
   always @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         since_cmd <= APPLY_CYC;
      end else if (any_wr) begin
         since_cmd <= 32'h0;
      end else if (since_cmd < APPLY_CYC) begin
         since_cmd <= since_cmd + 32'h1;
      end
   end
   AST_APPLY_LATE: assert property (
      $changed(DAC_POWER_DOWN) |-> since_cmd >= APPLY_CYC - 1) else $error("config applied early");
   AST_DAC_OFF: assert property (
      $rose(DAC_POWER_DOWN) |-> CONFIG_WORD[5:4] == `AOPS_OUTPUT_FORM_SELECT_PWM) else $error("dac off not pwm");
   AST_FAIL_LOW: assert property (
      PIN_PROG_FAIL && $past(PIN_PROG_FAIL, 3) |-> !OUT_OE_N && !OUT_O) else $error("fail not low");
   AST_FAIL_HOLD: assert property (
      $rose(PIN_PROG_FAIL) |=> PIN_PROG_FAIL [*8]) else $error("fail flag dropped");
   AST_DONE_HOLD: assert property (
      PIN_PROG_DONE |=> PIN_PROG_DONE) else $error("done flag dropped");
   AST_DONE_XOR: assert property (
      !(PIN_PROG_DONE && PIN_PROG_FAIL)) else $error("done and fail together");
   AST_PIN_MAGNET: assert property (
      $rose(PIN_PROG_DONE) || $rose(PIN_PROG_FAIL) |-> $past(MAGNET_PRESENT_FLAG, 2))
      else $error("pin programming without magnet");
   AST_PIN_OPTION: assert property (
      $rose(PIN_PROG_DONE) |-> !$past(PROGRAM_OPTION_PIN, 4)) else $error("option pin high");
   AST_BURN_SRC: assert property (
      $rose(SETTINGS_BURNED) |-> $past(COMMAND_WR) && $past(COMMAND_DATA) == 8'h40)
      else $error("burn flag without command");
   AST_BURN_HOLD: assert property (
      SETTINGS_BURNED |=> SETTINGS_BURNED) else $error("burn flag dropped");
   AST_RANGE_LOW: assert property (
      MAX_RANGE_WR && MAX_RANGE_DATA != 12'h000 && MAX_RANGE_DATA < 12'h0CD
      |=> $stable(MAX_RANGE_VALUE)) else $error("short range taken");
   AST_RANGE_OK: assert property (
      MAX_RANGE_WR && (MAX_RANGE_DATA == 12'h000 || MAX_RANGE_DATA >= 12'h0CD)
      |=> MAX_RANGE_VALUE == $past(MAX_RANGE_DATA)) else $error("range not taken");
endmodule // aops_top_chk

bind aops_top aops_top_chk #(.APPLY_CYC(APPLY_CYC), .PULSE_CYC(PULSE_CYC)) aops_top_chk_i (
   .CORE_CLK(CORE_CLK), .RST_N(RST_N), .MAGNET_PRESENT_FLAG(MAGNET_PRESENT_FLAG),
   .ZERO_POSITION_WR(ZERO_POSITION_WR), .MAX_RANGE_WR(MAX_RANGE_WR),
   .MAX_RANGE_DATA(MAX_RANGE_DATA), .CONFIG_WR(CONFIG_WR), .COMMAND_WR(COMMAND_WR),
   .COMMAND_DATA(COMMAND_DATA), .PROGRAM_OPTION_PIN(PROGRAM_OPTION_PIN),
   .MAX_RANGE_VALUE(MAX_RANGE_VALUE), .CONFIG_WORD(CONFIG_WORD),
   .SETTINGS_BURNED(SETTINGS_BURNED), .PIN_PROG_DONE(PIN_PROG_DONE),
   .PIN_PROG_FAIL(PIN_PROG_FAIL), .OUT_O(OUT_O), .OUT_OE_N(OUT_OE_N),
   .DAC_POWER_DOWN(DAC_POWER_DOWN));

/* testbench/aops_host.sv */
// host model pulling the output pin low, with the pin's pull-up
`timescale 1ns/1ps
module aops_host (
   // clock
   input  wire        clk,
   // pulse request
   input  wire        go,
   input  wire [15:0] len,
   output reg         busy,
   // pin
   input  wire        out_o,
   input  wire        out_oe_n,
   output wire        out_line
);
   reg        pull;
   reg [15:0] n;
   initial begin
      pull = 1'b0;
      busy = 1'b0;
      n = 16'h0000;
   end
   // hold the pin low for len cycles, then let it float
   always @(posedge clk) begin
      if (go && !busy) begin
         pull <= 1'b1;
         busy <= 1'b1;
         n <= len;
      end else if (busy) begin
         n <= n - 16'h0001;
         if (n <= 16'h0001) begin
            pull <= 1'b0;
            busy <= 1'b0;
         end
      end
   end
   // a low from either party wins, the pull-up gives high otherwise
   assign out_line = (pull || (!out_oe_n && !out_o)) ? 1'b0 : 1'b1;
endmodule // aops_host

/* testbench/tb.sv */
// self-checking testbench of the angle output stage
`timescale 1ns/1ps
`include "aops_consts.vh"
module tb;
   localparam integer APPLY = 20;
   localparam integer PULSE = 50;
   reg         clk, rst_n, mag, opt, zw, mw, cw, kw, go;
   reg  [11:0] raw, zd, md;
   reg  [13:0] cd;
   reg  [7:0]  kd;
   reg  [15:0] len;
   wire [11:0] ang, zv, mv, dac;
   wire [13:0] cv;
   wire        burned, done, fail, out_o, oe_n, dpd, line, busy;
   integer     fails, total_checks, cyc, n_hi, n_lo, k;
   aops_top #(.APPLY_CYC(APPLY), .PULSE_CYC(PULSE)) aops_top_i (
      .CORE_CLK(clk), .RST_N(rst_n), .RAW_ANGLE(raw), .MAGNET_PRESENT_FLAG(mag),
      .ZERO_POSITION_WR(zw), .ZERO_POSITION_DATA(zd), .MAX_RANGE_WR(mw), .MAX_RANGE_DATA(md),
      .CONFIG_WR(cw), .CONFIG_DATA(cd), .COMMAND_WR(kw), .COMMAND_DATA(kd),
      .ANGLE_VALUE(ang), .ZERO_POSITION_VALUE(zv), .MAX_RANGE_VALUE(mv), .CONFIG_WORD(cv),
      .SETTINGS_BURNED(burned), .PIN_PROG_DONE(done), .PIN_PROG_FAIL(fail),
      .PROGRAM_OPTION_PIN(opt), .OUT_IN(line), .OUT_O(out_o), .OUT_OE_N(oe_n),
      .DAC_CODE(dac), .DAC_POWER_DOWN(dpd));
   aops_host aops_host_i (.clk(clk), .go(go), .len(len), .busy(busy), .out_o(out_o),
      .out_oe_n(oe_n), .out_line(line));
   always #25 clk = ~clk;
   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   task end_sim;
      begin
         $display("checks=%0d mismatches=%0d", total_checks, fails);
         if (fails == 0 && total_checks > 0) begin
            $display("Testbench passed");
         end else begin
            $display("Testbench failed");
         end
         $finish;
      end
   endtask
   task chk(input [31:0] got, input [31:0] exp);
      begin
         total_checks = total_checks + 1;
         if (got !== exp) begin
            fails = fails + 1;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   // sel 0 zero, 1 range, 2 config, 3 command
   task wr(input integer sel, input [13:0] d);
      begin
         @(posedge clk);
         zw <= (sel == 0);
         mw <= (sel == 1);
         cw <= (sel == 2);
         kw <= (sel == 3);
         zd <= d[11:0];
         md <= d[11:0];
         cd <= d;
         kd <= d[7:0];
         @(posedge clk);
         {zw, mw, cw, kw} <= 4'h0;
      end
   endtask
   task settle;
      repeat (APPLY + 60) @(posedge clk);
   endtask
   task do_reset;
      begin
         @(posedge clk);
         rst_n <= 1'b0;
         repeat (4) @(posedge clk);
         rst_n <= 1'b1;
         repeat (4) @(posedge clk);
      end
   endtask
   task pulse;
      begin
         @(posedge clk);
         len <= PULSE + 10;
         go <= 1'b1;
         @(posedge clk);
         go <= 1'b0;
         k = 0;
         @(posedge clk);
         while (busy !== 1'b0 && k < 500) begin
            @(posedge clk);
            k = k + 1;
         end
         chk(busy, 1'b0);
         repeat (40) @(posedge clk);
      end
   endtask
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task t_reset;
      begin
         chk({zv, mv}, 24'h0);
         chk({cv, burned, done, fail, dpd}, 18'h0);
         $display("test reset ended");
      end
   endtask
   task t_range;
      begin
         raw <= 12'h400;
         wr(1, 14'h00CC);
         repeat (2) @(posedge clk);
         chk(mv, 12'h000);
         wr(1, 14'h0800);
         settle;
         chk(mv, 12'h800);
         chk(ang, 12'h800);
         raw <= 12'hA00;
         settle;
         chk(ang, 12'hFFF);
         raw <= 12'h400;
         wr(1, 14'h0000);
         settle;
         chk(ang, 12'h400);
         wr(0, 14'h0400);
         settle;
         chk({zv, ang}, 24'h400000);
         raw <= 12'h3FE;
         settle;
         chk(ang, 12'h000);
         raw <= 12'h400;
         wr(0, 14'h0000);
         settle;
         $display("test range ended");
      end
   endtask
   task t_analog;
      begin
         chk(dac, 12'h400);
         wr(2, 14'h0010);
         repeat (5) @(posedge clk);
         chk(dac, 12'h400);
         settle;
         chk(dac, `AOPS_LOW_OFS + 12'h333);
         wr(2, 14'h0000);
         settle;
         chk({dpd, dac}, 13'h0400);
         $display("test analog ended");
      end
   endtask
   task t_pwm;
      begin
         raw <= 12'h800;
         wr(2, 14'h0020);
         settle;
         chk(dpd, 1'b1);
         chk(ang, 12'h800);
         for (k = 0; k < 20000 && out_o !== 1'b0; k = k + 1) @(posedge clk);
         for (k = 0; k < 20000 && out_o !== 1'b1; k = k + 1) @(posedge clk);
         for (n_hi = 0; n_hi < 20000 && out_o === 1'b1; n_hi = n_hi + 1) @(posedge clk);
         for (n_lo = 0; n_lo < 20000 && out_o === 1'b0; n_lo = n_lo + 1) @(posedge clk);
         chk(n_hi, (`AOPS_PWM_EDGE + 12'h800) * `AOPS_PWM_BASE_DIV);
         chk(n_lo, (`AOPS_PWM_FRAME - `AOPS_PWM_EDGE - 12'h800) * `AOPS_PWM_BASE_DIV);
         chk(oe_n, 1'b0);
         wr(2, 14'h0000);
         settle;
         $display("test pwm ended");
      end
   endtask
   task t_burn;
      begin
         wr(1, 14'h0800);
         wr(2, 14'h0010);
         wr(3, 14'h0040);
         settle;
         chk(burned, 1'b1);
         wr(1, 14'h0400);
         wr(3, 14'h0040);
         settle;
         wr(1, 14'h0C00);
         wr(2, 14'h0000);
         wr(3, 14'h0001);
         wr(3, 14'h0011);
         wr(3, 14'h0010);
         repeat (2) @(posedge clk);
         chk(mv, 12'h800);
         chk(cv, 14'h0010);
         $display("test burn ended");
      end
   endtask
   task t_pin_ok;
      begin
         do_reset;
         opt <= 1'b0;
         mag <= 1'b0;
         raw <= 12'h100;
         pulse;
         pulse;
         chk(done, 1'b0);
         mag <= 1'b1;
         repeat (10) @(posedge clk);
         pulse;
         chk({done, zv}, 13'h0000);
         raw <= 12'h900;
         pulse;
         chk({done, fail, zv, mv}, 26'h2100800);
         raw <= 12'h300;
         pulse;
         pulse;
         chk({zv, mv}, 24'h100800);
         opt <= 1'b1;
         repeat (10) @(posedge clk);
         chk({oe_n, dac}, 13'h1400);
         $display("test pin ok ended");
      end
   endtask
   task t_pin_fail;
      begin
         do_reset;
         opt <= 1'b0;
         raw <= 12'h100;
         pulse;
         raw <= 12'h110;
         pulse;
         opt <= 1'b1;
         repeat (50) @(posedge clk);
         chk({fail, done, oe_n, out_o}, 4'h8);
         $display("test pin fail ended");
      end
   endtask
   // ----------------------------------------------------------------
   // main sequence and run limit
   // ----------------------------------------------------------------
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 90000) begin
         fails = fails + 1;
         end_sim;
      end
   end
   initial begin
      {clk, rst_n, zw, mw, cw, kw, go} = 7'h00;
      {mag, opt} = 2'h3;
      {raw, zd, md, cd, kd, len} = 74'h0;
      {fails, total_checks, cyc} = 0;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      t_reset;
      t_range;
      t_analog;
      t_pwm;
      t_burn;
      t_pin_ok;
      t_pin_fail;
      end_sim;
   end
endmodule // tb
